// File: hdl/rtcs_serial_slave.v
// two-wire serial slave with bcd clock/calendar and supply lockout
//
// Overview of operation
// - slave only; selected by start followed by fixed address d0h
// - eight byte locations: seconds to years, then control, in sequence
// - supply below threshold aborts the access and clears the pointer
// - supply below threshold: all bus inputs ignored, no bus writes; the seconds tick still updates the clock
// - bus inputs recognised again once the supply is back
// - data line held stable by its driver while clock is high
// - data change while clock high is a control condition
// - bus idle while both lines stay high
// - start is data falling while clock high
// - stop is data rising while clock high
// - transmitter changes data only while clock is low
// - one clock pulse per data bit
// - every transfer opens with start and closes with stop
// - any number of bytes accepted between start and stop
// - bytes of eight bits, receiver acknowledges on ninth bit
// - pointer advances after each data byte written, or read and acknowledged
// - clock/calendar bytes held in bcd
// - 32.768 khz crystal divided down to drive seconds
// - counters seconds to century, with automatic leap-year handling
// - test/level pin driven open drain
// - slave receiver acks each byte; master nack ends a read
// - pointer advances on a read only when master acknowledges
// - write: first byte loads pointer, later bytes stored and advance
// - read without address starts at current pointer
`timescale 1ns/10ps
// constants are needed by the parameter default, so they come in ahead of the header
`include "rtcs_defines.vh"
module rtcs_serial_slave #(
  parameter CRYSTAL_DIV = `RTCS_CRYSTAL_HZ
) (
  input wire clk,
  input wire nrst,
  input wire sclIn,
  input wire sdaIn,
  output wire sdaOut,
  output reg sdaOe_q,
  input wire crystalIn,
  input wire mainSupplyOk,
  output wire testOrLevelPinOut,
  output reg testOrLevelPinOe_q
);

localparam [4:0] S_IDLE = 5'b00001;
localparam [4:0] S_RX = 5'b00010;
localparam [4:0] S_ACK = 5'b00100;
localparam [4:0] S_TX = 5'b01000;
localparam [4:0] S_RACK = 5'b10000;
localparam integer DIV_LAST_I = CRYSTAL_DIV - 1;
localparam [15:0] DIV_LAST = DIV_LAST_I[15:0]; // divider is 16 bits wide

////////////////////////////////////////////////////////////////////////
// bcd helpers

// one bcd step with wrap; returns {carry, value}
function [8:0] bcdStep;
  input [7:0] v;
  input [7:0] maxv;
  input [7:0] minv;
  input en;
  begin
    if (!en) begin
      bcdStep = {1'b0, v};
    end else if (v >= maxv) begin
      bcdStep = {1'b1, minv};
    end else if (v[3:0] == 4'h9) begin
      bcdStep = {1'b0, v[7:4] + 4'h1, 4'h0};
    end else begin
      bcdStep = {1'b0, v + 8'h01};
    end
  end
endfunction

// last date of a month, bcd month and year
function [7:0] lastDate;
  input [7:0] mon;
  input [7:0] yr;
  reg leap;
  begin
    // year divisible by four, read straight off the bcd digits
    if (yr[4]) begin
      leap = (yr[3:0] == 4'h2) || (yr[3:0] == 4'h6);
    end else begin
      leap = (yr[3:0] == 4'h0) || (yr[3:0] == 4'h4) || (yr[3:0] == 4'h8);
    end
    case (mon)
      8'h02: lastDate = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: lastDate = 8'h30;
      default: lastDate = 8'h31;
    endcase
  end
endfunction

////////////////////////////////////////////////////////////////////////
// pin synchronisers: three stages, a change counts once 2nd and 3rd agree
reg [3:0] sync1_q;
reg [3:0] sync2_q;
reg [3:0] sync3_q;
reg [3:0] filt_q;
reg sclPrev_q;
reg sdaPrev_q;

always @(posedge clk) begin
  if (!nrst) begin
    sync1_q <= `RTCS_SYNC_RESET;
    sync2_q <= `RTCS_SYNC_RESET;
    sync3_q <= `RTCS_SYNC_RESET;
    filt_q <= `RTCS_SYNC_RESET;
    sclPrev_q <= 1'b1;
    sdaPrev_q <= 1'b1;
  end else begin
    sync1_q <= {mainSupplyOk, crystalIn, sdaIn, sclIn};
    sync2_q <= sync1_q;
    sync3_q <= sync2_q;
    filt_q <= (sync2_q & sync3_q) | (filt_q & (sync2_q ^ sync3_q));
    sclPrev_q <= filt_q[0];
    sdaPrev_q <= filt_q[1];
  end
end

wire sclS = filt_q[0];
wire sdaS = filt_q[1];
wire crystalS = filt_q[2];
wire supplyOk = filt_q[3];
wire sclRise = sclS & ~sclPrev_q;
wire sclFall = ~sclS & sclPrev_q;
// data edges with clock held high are conditions, never bits
wire startSeen = sclS & sclPrev_q & sdaPrev_q & ~sdaS;
wire stopSeen = sclS & sclPrev_q & ~sdaPrev_q & sdaS;

////////////////////////////////////////////////////////////////////////
// register store
reg busWe_q;
reg [2:0] busAddr_q;
reg [7:0] busData_q;
reg [2:0] ptr_q;
wire [7:0] rdData;
wire [63:0] allData;
reg secTick;
reg [55:0] tickData;

rtcs_regfile u_regs (
  .clk(clk),
  .nrst(nrst),
  .busWe(busWe_q),
  .busAddr(busAddr_q),
  .busData(busData_q),
  .tickWe(secTick),
  .tickData(tickData),
  .rdAddr(ptr_q),
  .rdData_q(rdData),
  .allData(allData)
);

////////////////////////////////////////////////////////////////////////
// crystal prescaler: one seconds tick per CRYSTAL_DIV rising crystal edges
reg [15:0] presc_q;
reg crystalPrev_q;
wire stopOsc = allData[`RTCS_ST_BIT];

always @(posedge clk) begin
  if (!nrst) begin
    presc_q <= 16'h0000;
    crystalPrev_q <= 1'b0;
    secTick <= 1'b0;
  end else begin
    crystalPrev_q <= crystalS;
    secTick <= 1'b0;
    if (stopOsc) begin
      presc_q <= 16'h0000; // stopped oscillator holds the divider at zero
    end else if (crystalS & ~crystalPrev_q) begin
      if (presc_q == DIV_LAST) begin
        presc_q <= 16'h0000;
        secTick <= 1'b1;
      end else begin
        presc_q <= presc_q + 16'h0001;
      end
    end
  end
end

////////////////////////////////////////////////////////////////////////
// calendar ripple: next bcd image of bytes 0..6, stored on secTick
reg [8:0] rSec;
reg [8:0] rMin;
reg [8:0] rHour;
reg [8:0] rDay;
reg [8:0] rDate;
reg [8:0] rMon;
reg [8:0] rYear;
reg cbNext;

always @* begin
  rSec = bcdStep({1'b0, allData[6:0]}, 8'h59, 8'h00, 1'b1);
  rMin = bcdStep({1'b0, allData[14:8]}, 8'h59, 8'h00, rSec[8]);
  rHour = bcdStep({2'b00, allData[21:16]}, 8'h23, 8'h00, rMin[8]);
  rDay = bcdStep({5'b00000, allData[26:24]}, 8'h07, 8'h01, rHour[8]);
  rDate = bcdStep({2'b00, allData[37:32]},
                  lastDate({3'b000, allData[44:40]}, allData[55:48]), 8'h01, rHour[8]);
  rMon = bcdStep({3'b000, allData[44:40]}, 8'h12, 8'h01, rDate[8]);
  rYear = bcdStep(allData[55:48], 8'h99, 8'h00, rMon[8]);
  // century flag toggles at the year wrap only when enabled
  cbNext = allData[16 + `RTCS_CB_BIT] ^ (rYear[8] & allData[16 + `RTCS_CEB_BIT]);
  tickData = {rYear[7:0],
              3'b000, rMon[4:0],
              2'b00, rDate[5:0],
              5'b00000, rDay[2:0],
              allData[16 + `RTCS_CEB_BIT], cbNext, rHour[5:0],
              1'b0, rMin[6:0],
              allData[`RTCS_ST_BIT], rSec[6:0]};
end

////////////////////////////////////////////////////////////////////////
// test/level pin: open drain, square wave in test mode, else a level
wire [7:0] ctrlByte = allData[63:56];

assign testOrLevelPinOut = 1'b0;

always @(posedge clk) begin
  if (!nrst) begin
    testOrLevelPinOe_q <= 1'b0;
  end else if (ctrlByte[`RTCS_FT_BIT]) begin
    testOrLevelPinOe_q <= ~presc_q[`RTCS_FT_TAP];
  end else begin
    testOrLevelPinOe_q <= ~ctrlByte[`RTCS_OUT_BIT];
  end
end

////////////////////////////////////////////////////////////////////////
// serial slave state machine
reg [4:0] state_q;
reg [3:0] cnt_q;
reg [7:0] shift_q;
reg [1:0] kind_q;
reg rw_q;
reg load_q;
reg ackSeen_q;

// data pin only ever pulls low; the pull-up makes the high level
assign sdaOut = 1'b0;

always @(posedge clk) begin
  if (!nrst) begin
    state_q <= S_IDLE;
    cnt_q <= 4'h0;
    shift_q <= 8'h00;
    kind_q <= `RTCS_KIND_SADR;
    rw_q <= 1'b0;
    load_q <= 1'b0;
    ackSeen_q <= 1'b0;
    ptr_q <= 3'h0;
    sdaOe_q <= 1'b0;
    busWe_q <= 1'b0;
    busAddr_q <= 3'h0;
    busData_q <= 8'h00;
  end else if (!supplyOk) begin
    // low supply: drop the access, clear the pointer, ignore the pins
    state_q <= S_IDLE;
    ptr_q <= 3'h0;
    sdaOe_q <= 1'b0;
    busWe_q <= 1'b0;
    load_q <= 1'b0;
  end else begin
    // supply back: pins are heard again from here on
    busWe_q <= 1'b0;
    if (startSeen) begin
      // repeated start is legal anywhere and restarts address capture
      state_q <= S_RX;
      kind_q <= `RTCS_KIND_SADR;
      cnt_q <= 4'h0;
      sdaOe_q <= 1'b0;
      load_q <= 1'b0;
    end else if (stopSeen) begin
      state_q <= S_IDLE;
      sdaOe_q <= 1'b0;
      load_q <= 1'b0;
    end else begin
      case (state_q)
        S_IDLE: begin
          sdaOe_q <= 1'b0;
        end
        S_RX: begin
          if (sclRise && cnt_q < 4'h8) begin
            shift_q <= {shift_q[6:0], sdaS};
            cnt_q <= cnt_q + 4'h1;
          end else if (sclFall && cnt_q == 4'h8) begin
            case (kind_q)
              `RTCS_KIND_SADR: begin
                if (shift_q[7:1] == `RTCS_SLAVE_ADDR) begin
                  rw_q <= shift_q[0];
                  state_q <= S_ACK;
                  sdaOe_q <= 1'b1;
                end else begin
                  state_q <= S_IDLE; // not us: stay off the bus until start
                end
              end
              `RTCS_KIND_WADR: begin
                ptr_q <= shift_q[2:0];
                state_q <= S_ACK;
                sdaOe_q <= 1'b1;
              end
              default: begin
                busWe_q <= 1'b1;
                busAddr_q <= ptr_q;
                busData_q <= shift_q;
                state_q <= S_ACK;
                sdaOe_q <= 1'b1;
              end
            endcase
          end
        end
        S_ACK: begin
          if (sclFall) begin
            sdaOe_q <= 1'b0;
            cnt_q <= 4'h0;
            if (kind_q == `RTCS_KIND_DATA) begin
              ptr_q <= ptr_q + 3'h1;
            end
            if (kind_q == `RTCS_KIND_SADR && rw_q) begin
              state_q <= S_TX;
              load_q <= 1'b1;
            end else if (kind_q == `RTCS_KIND_SADR) begin
              kind_q <= `RTCS_KIND_WADR;
              state_q <= S_RX;
            end else begin
              kind_q <= `RTCS_KIND_DATA;
              state_q <= S_RX;
            end
          end
        end
        S_TX: begin
          // new bits go out only just after a falling clock
          if (load_q) begin
            load_q <= 1'b0;
            shift_q <= rdData;
            sdaOe_q <= ~rdData[7];
          end else if (sclFall) begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == 4'h7) begin
              state_q <= S_RACK;
              sdaOe_q <= 1'b0; // release for the master's answer
            end else begin
              shift_q <= {shift_q[6:0], 1'b0};
              sdaOe_q <= ~shift_q[6];
            end
          end
        end
        S_RACK: begin
          if (sclRise) begin
            ackSeen_q <= ~sdaS;
            if (!sdaS) begin
              ptr_q <= ptr_q + 3'h1;
            end
          end else if (sclFall) begin
            cnt_q <= 4'h0;
            if (ackSeen_q) begin
              state_q <= S_TX;
              load_q <= 1'b1;
            end else begin
              state_q <= S_IDLE;
            end
          end
        end
        default: begin
          state_q <= S_IDLE;
          sdaOe_q <= 1'b0;
        end
      endcase
    end
  end
end

endmodule // rtcs_serial_slave

// File: hdl/rtcs_defines.vh
// constants shared by the serial clock slave and its register store
`ifndef RTCS_DEFINES_VH
`define RTCS_DEFINES_VH

// bus identity: 8-bit select byte d0 with the direction bit cleared
`define RTCS_SLAVE_ADDR 7'h68
`define RTCS_NUM_REGS 8
`define RTCS_PTR_W 3

// register indices
`define RTCS_IDX_SEC 3'h0
`define RTCS_IDX_MIN 3'h1
`define RTCS_IDX_HOUR 3'h2
`define RTCS_IDX_DAY 3'h3
`define RTCS_IDX_DATE 3'h4
`define RTCS_IDX_MONTH 3'h5
`define RTCS_IDX_YEAR 3'h6
`define RTCS_IDX_CTRL 3'h7

// field positions
`define RTCS_ST_BIT 7
`define RTCS_CEB_BIT 7
`define RTCS_CB_BIT 6
`define RTCS_OUT_BIT 7
`define RTCS_FT_BIT 6

// reset image, byte 0 in the low bits: day, date and month start at 01
`define RTCS_REG_RESET 64'h0000010101000000

// byte kinds seen by the receiver
`define RTCS_KIND_SADR 2'h0
`define RTCS_KIND_WADR 2'h1
`define RTCS_KIND_DATA 2'h2

// timekeeping: rising crystal edges per second, and test tap (512 hz square)
`define RTCS_CRYSTAL_HZ 32768
`define RTCS_FT_TAP 5

// synchroniser reset image {supply, crystal, sda, scl}
`define RTCS_SYNC_RESET 4'h3

`endif

// File: hdl/rtcs_regfile.v
// eight-byte clock/calendar store with registered read port
`timescale 1ns/10ps
module rtcs_regfile (
  input wire clk,
  input wire nrst,
  input wire busWe,
  input wire [2:0] busAddr,
  input wire [7:0] busData,
  input wire tickWe,
  input wire [55:0] tickData,
  input wire [2:0] rdAddr,
  output reg [7:0] rdData_q,
  output wire [63:0] allData
);
`include "rtcs_defines.vh"

reg [63:0] mem_q;
integer i;

assign allData = mem_q;

////////////////////////////////////////////////////////////////////////
// bus write is applied after the tick so a software set is never lost
always @(posedge clk) begin
  if (!nrst) begin
    mem_q <= `RTCS_REG_RESET;
    rdData_q <= 8'h00;
  end else begin
    if (tickWe) begin
      for (i = 0; i < 7; i = i + 1) begin
        mem_q[i*8 +: 8] <= tickData[i*8 +: 8];
      end
    end
    if (busWe) begin
      mem_q[{busAddr, 3'b000} +: 8] <= busData;
    end
    rdData_q <= mem_q[{rdAddr, 3'b000} +: 8];
  end
end

endmodule // rtcs_regfile

// File: verif/rtcs_serial_slave_asserts.sv
// port-level checks for the serial clock slave
`timescale 1ns/10ps
module rtcs_serial_slave_asserts (
  input wire clk,
  input wire nrst,
  input wire sclIn,
  input wire sdaIn,
  input wire sdaOut,
  input wire sdaOe_q,
  input wire crystalIn,
  input wire mainSupplyOk,
  input wire testOrLevelPinOut,
  input wire testOrLevelPinOe_q
);
  reg sdaPrev_q;
  reg sclPrev_q;
  reg [7:0] riseCnt_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  //////////////////////////////////////////////////////////////////////////////
  // scl rises seen at the pins since the last start, saturating
  always @(posedge clk) begin
    if (!nrst) begin
      sdaPrev_q <= 1'b1;
      sclPrev_q <= 1'b1;
      riseCnt_q <= 8'h00;
    end else begin
      sdaPrev_q <= sdaIn;
      sclPrev_q <= sclIn;
      if (sclIn && sclPrev_q && sdaPrev_q && !sdaIn) begin
        riseCnt_q <= 8'h00;
      end else if (sclIn && !sclPrev_q && riseCnt_q != 8'hff) begin
        riseCnt_q <= riseCnt_q + 8'h01;
      end
    end
  end
  a_sda_low_only: assert property (sdaOut == 1'b0)
    else $error("data line driven high");
  a_pin_open_drain: assert property (testOrLevelPinOut == 1'b0)
    else $error("test pin driven high");
  a_reset_quiet: assert property ($rose(nrst) |-> !sdaOe_q && !testOrLevelPinOe_q)
    else $error("pins pulled low right after reset");
  a_pin_after_reset: assert property ($rose(nrst) |=> testOrLevelPinOe_q)
    else $error("test pin not low for cleared output bit");
  a_lockout_quiet: assert property (!mainSupplyOk [*8] |-> !sdaOe_q)
    else $error("data line pulled during supply lockout");
  a_oe_changes_low: assert property ($changed(sdaOe_q) && mainSupplyOk |-> !$past(sclIn, 2))
    else $error("data drive changed outside clock low phase");
  a_oe_hold_high: assert property ($rose(sclIn) && sdaOe_q |=> sdaOe_q [*4])
    else $error("data drive dropped while clock high");
  a_ack_after_byte: assert property ($rose(sdaOe_q) |-> riseCnt_q >= 8'h08)
    else $error("data line pulled before eight bits");
endmodule // rtcs_serial_slave_asserts

// File: verif/rtcs_bus_master.sv
// behavioural two-wire bus master, pulls data low only, drives the clock both ways
`timescale 1ns/10ps
module rtcs_bus_master (
  input wire clk,
  input wire sdaBus,
  output reg sclOut,
  output reg sdaLow
);
  // data released to the pull-up, clock driven high: the idle level
  initial begin
    sclOut = 1'b1;
    sdaLow = 1'b0;
  end
  // one bit: 6 clocks low, 2 high; sampled late in high for settled data
  task bit_io(input logic b, output logic r);
    @(posedge clk) sdaLow <= !b;
    repeat (5) @(posedge clk);
    sclOut <= 1'b1;
    @(posedge clk);
    @(negedge clk) r = sdaBus;
    @(posedge clk) sclOut <= 1'b0;
  endtask
  task send_byte(input [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task recv_byte(input logic ack, output [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(!ack, r);
  endtask
  // called from idle or after a ninth bit; waits out the slave's ack release
  task start;
    @(posedge clk) sdaLow <= 1'b0;
    repeat (6) @(posedge clk);
    sclOut <= 1'b1;
    repeat (4) @(posedge clk);
    sdaLow <= 1'b1;
    repeat (4) @(posedge clk);
    sclOut <= 1'b0;
  endtask
  task stop;
    @(posedge clk) sdaLow <= 1'b1;
    repeat (6) @(posedge clk);
    sclOut <= 1'b1;
    repeat (4) @(posedge clk);
    sdaLow <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
endmodule // rtcs_bus_master

// File: verif/rtc_serial_slave_access_test.sv
// self-checking bench for the serial clock slave
`timescale 1ns/10ps
module rtc_serial_slave_access_test;
  reg clk = 1'b0;
  reg nrst = 1'b0;
  reg mainSupplyOk = 1'b1;
  reg crystalIn = 1'b0;
  reg ack;
  reg [7:0] rdByte;
  wire sclBus;
  wire sdaBus;
  wire masterLow;
  wire sdaOut;
  wire sdaOe_q;
  wire pinOut;
  wire pinOe;
  integer badCount = 0;
  integer samplesChecked = 0;
  always #50 clk = ~clk;
  // crystal stand-in, 30 clocks a period so a second is 8 rises
  always begin
    repeat (15) @(posedge clk);
    crystalIn <= ~crystalIn;
  end
  // wired-and over the pull-up
  assign sdaBus = !masterLow && !(sdaOe_q && !sdaOut);
  rtcs_serial_slave #(.CRYSTAL_DIV(8)) rtcs_serial_slave_inst (
    .clk(clk), .nrst(nrst), .sclIn(sclBus), .sdaIn(sdaBus), .sdaOut(sdaOut),
    .sdaOe_q(sdaOe_q), .crystalIn(crystalIn), .mainSupplyOk(mainSupplyOk),
    .testOrLevelPinOut(pinOut), .testOrLevelPinOe_q(pinOe));
  rtcs_bus_master rtcs_bus_master_inst (
    .clk(clk), .sdaBus(sdaBus), .sclOut(sclBus), .sdaLow(masterLow));
  //////////////////////////////////////////////////////////////////////////////
  task give_verdict;
    $display("comparisons %0d, mismatches %0d", samplesChecked, badCount);
    if (badCount == 0 && samplesChecked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task check(input string what, input [7:0] expv, input [7:0] got);
    samplesChecked = samplesChecked + 1;
    if (got !== expv) begin
      $display("unexpected %s: expected %h, seen %h", what, expv, got);
      badCount = badCount + 1;
    end
  endtask
  // byte out, ninth bit compared with the expected answer
  task tx(input [7:0] d, input logic e);
    rtcs_bus_master_inst.send_byte(d, ack);
    check("ack", {7'h00, e}, {7'h00, ack});
  endtask
  task rx(input logic mAck, input [7:0] e);
    rtcs_bus_master_inst.recv_byte(mAck, rdByte);
    check("read byte", e, rdByte);
  endtask
  task sta;
    rtcs_bus_master_inst.start;
  endtask
  task sto;
    rtcs_bus_master_inst.stop;
  endtask
  // burst from month across the wrap; stops the seconds, frees the pin
  task write_wrap;
    sta;
    tx(8'hd0, 1'b1);
    tx(8'h05, 1'b1);
    tx(8'h12, 1'b1);
    tx(8'h99, 1'b1);
    tx(8'h80, 1'b1);
    tx(8'h80, 1'b1);
    tx(8'h59, 1'b1);
    sto;
    check("pin enable", 8'h00, {7'h00, pinOe});
  endtask
  // held pointer, loaded pointer, and a refused ack leaving it in place
  task read_seq;
    sta;
    tx(8'hd1, 1'b1);
    rx(1'b1, 8'h00);
    rx(1'b1, 8'h01);
    rx(1'b0, 8'h01);
    sto;
    sta;
    tx(8'hd0, 1'b1);
    tx(8'h05, 1'b1);
    sta;
    tx(8'hd1, 1'b1);
    rx(1'b1, 8'h12);
    rx(1'b0, 8'h99);
    sto;
    sta;
    tx(8'hd1, 1'b1);
    rx(1'b0, 8'h99);
    sto;
  endtask
  // a foreign address, then silence until a new start
  task wrong_addr;
    sta;
    tx(8'ha0, 1'b0);
    tx(8'hd0, 1'b0);
    sto;
  endtask
  // supply loss in mid-write drops the byte and clears the pointer
  task lockout;
    sta;
    tx(8'hd0, 1'b1);
    tx(8'h03, 1'b1);
    mainSupplyOk <= 1'b0;
    repeat (8) @(posedge clk);
    tx(8'h07, 1'b0);
    sto;
    mainSupplyOk <= 1'b1;
    repeat (8) @(posedge clk);
    sta;
    tx(8'hd1, 1'b1);
    rx(1'b0, 8'h80);
    sto;
    sta;
    tx(8'hd0, 1'b1);
    tx(8'h03, 1'b1);
    sta;
    tx(8'hd1, 1'b1);
    rx(1'b0, 8'h01);
    sto;
  endtask
  // one tick carries 23:59:59, 28 feb of a common year into 1 march
  task calendar;
    sta;
    tx(8'hd0, 1'b1);
    tx(8'h01, 1'b1);
    tx(8'h59, 1'b1);
    tx(8'h23, 1'b1);
    tx(8'h07, 1'b1);
    tx(8'h28, 1'b1);
    tx(8'h02, 1'b1);
    tx(8'h03, 1'b1);
    tx(8'h80, 1'b1);
    tx(8'h59, 1'b1);
    sto;
    repeat (300) @(posedge clk);
    sta;
    tx(8'hd1, 1'b1);
    rx(1'b1, 8'h00);
    rx(1'b1, 8'h00);
    rx(1'b1, 8'h01);
    rx(1'b1, 8'h01);
    rx(1'b1, 8'h03);
    rx(1'b0, 8'h03);
    sto;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    repeat (10) @(posedge clk);
    check("pin enable", 8'h01, {7'h00, pinOe});
    write_wrap;
    read_seq;
    wrong_addr;
    lockout;
    calendar;
    give_verdict;
  end
  // hang guard, about five times the expected run
  initial begin
    repeat (20000) @(posedge clk);
    badCount = badCount + 1;
    give_verdict;
  end
endmodule // rtc_serial_slave_access_test
bind rtcs_serial_slave rtcs_serial_slave_asserts rtcs_serial_slave_asserts_inst (
  .clk(clk), .nrst(nrst), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe_q(sdaOe_q),
  .crystalIn(crystalIn), .mainSupplyOk(mainSupplyOk), .testOrLevelPinOut(testOrLevelPinOut),
  .testOrLevelPinOe_q(testOrLevelPinOe_q));
